// file: fb_result_pkg.sv
// Package: register map, field layout, reset values and carriers
package fb_result_pkg;

   // Register index map of the read port
   localparam logic [7:0] A_INSTR_STATUS = 8'h00;
   localparam logic [7:0] A_ERROR_CODE = 8'h01;
   localparam logic [7:0] A_INPUT_FAULT = 8'h02;
   localparam logic [7:0] A_SUM = 8'h03;
   localparam logic [7:0] A_DIFF = 8'h04;
   localparam logic [7:0] A_OUT1 = 8'h05;
   localparam logic [7:0] A_FORCE_A = 8'h0D;

   // Counts of outputs and inputs per function block
   localparam int N_OUT = 8;
   localparam int N_IN = 4;

   // Field positions
   localparam int RESTART_BIT = 1;
   localparam int FAULT_LSB = 0;

   // Reset values
   localparam logic RESTART_RST = 1'b1;
   localparam logic [15:0] ERROR_CODE_RST = 16'h0000;
   localparam logic [31:0] RD_DATA_RST = 32'h0000_0000;

   // Decimal weight of the channel digit in an error code (X255)
   localparam logic [15:0] CHAN_WEIGHT = 16'h03E8;
   localparam logic [2:0] CHAN_MAX = 3'h4;

   // Origin of a register read
   typedef enum logic [1:0] {
      SRC_SERIAL = 2'b00,
      SRC_ETHERNET = 2'b01,
      SRC_FIELDBUS = 2'b10
   } rd_src_t;

   // Read request from the protocol engine
   typedef struct packed {
      logic req;
      logic [7:0] addr;
      rd_src_t src;
   } rd_req_t;

   // Error report from the measurement logic
   typedef struct packed {
      logic present;
      logic valid;
      logic [2:0] chan;
      logic [7:0] code;
   } err_rep_t;

   // Results of one function block
   typedef struct packed {
      logic [31:0] sum;
      logic [31:0] diff;
      logic [N_OUT-1:0][31:0] outv;
      logic [N_OUT-1:0] out_used;
      logic [N_IN-1:0][31:0] force_v;
      logic [N_IN-1:0] in_used;
      logic [N_IN-1:0] in_fault;
   } fb_result_t;

endpackage

// file: first_error_latch.sv
// First-error capture and decimal encoding for one function block
`timescale 1ns/100ps
module first_error_latch
   import fb_result_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // Error report
   input err_rep_t err,
   // Latched code
   output logic [15:0] code_q
);

   logic held_q;
   logic [15:0] enc;
   logic [2:0] chan;

   ////////////////////////////////////////////////////////////////////////
   // Encoding: channel digit 1-4 prefixed to a three-digit code
   always_comb begin
      chan = (err.chan > CHAN_MAX) ? CHAN_MAX : err.chan;
      enc = 16'(16'(chan) * CHAN_WEIGHT) + 16'(err.code); // RULE_03
   end

   ////////////////////////////////////////////////////////////////////////
   // Capture wins over the clear so a fresh error is never lost
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         code_q <= ERROR_CODE_RST;
         held_q <= 1'b0;
      end else if (err.valid && !held_q) begin
         code_q <= enc; // RULE_01
         held_q <= 1'b1;
      end else if (!err.present && !err.valid) begin
         code_q <= ERROR_CODE_RST; // RULE_02
         held_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   first_hold_a: assert property (@(posedge core_clk) // RULE_01
      disable iff (!arst_n)
      held_q && err.present |=> $stable(code_q))
      else $error("latched error code was overwritten");
   no_error_zero_a: assert property (@(posedge core_clk) // RULE_02
      disable iff (!arst_n)
      !err.present && !err.valid |=> code_q == 16'h0000)
      else $error("error code not zero without error");
   code_range_a: assert property (@(posedge core_clk) // RULE_03
      disable iff (!arst_n)
      err.valid && !held_q
      |=> code_q <= 16'h109F && code_q % 16'h03E8 < 16'h0100)
      else $error("error code out of encoded range");
   err_latched_c: cover property (@(posedge core_clk) disable iff (!arst_n)
      err.valid && !held_q ##1 err.valid);

endmodule

// file: fb_result_regs.sv
// Read-only result and diagnostic registers of one function block
`timescale 1ns/100ps
// What this block does
// RULE_01: Keep earliest error code, ignore later ones
// RULE_02: Error code reads zero without error
// RULE_03: Code is 0-255, optionally channel digit 1-4
// RULE_04: Status bits 0-3 flag inputs A-D faulty
// RULE_05: Status bits 4-15 read zero
// RULE_06: Sum value readable per block
// RULE_07: Difference value readable per block
// RULE_08: Master trusts values only when code zero
// RULE_09: Eight output registers behave like output one
// RULE_10: Unused outputs read zero
// RULE_11: Force per input, unused input reads zero
// RULE_12: Restart flag, cleared by serial/Ethernet status read
module fb_result_regs
   import fb_result_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // Read port from the register protocol engine
   input rd_req_t rd,
   // Dedicated restart-flag clear command from the fieldbus side
   input wire logic fieldbus_restart_clr,
   // Block results from the measurement logic
   input fb_result_t res,
   input err_rep_t err,
   // Read answer
   output logic rd_valid_q,
   output logic [31:0] rd_data_q,
   output logic rd_unmapped_q,
   // Program restart indication
   output logic restart_q
);

   logic [15:0] err_code;
   logic [N_OUT-1:0][31:0] out_shown;
   logic [N_IN-1:0][31:0] force_shown;
   logic [31:0] rd_mux;
   logic rd_hit;
   logic [2:0] out_idx;
   logic [1:0] in_idx;
   logic status_rd_clr;

   ////////////////////////////////////////////////////////////////////////
   // First-error capture
   first_error_latch u_latch (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .err(err),
      .code_q(err_code)
   );

   ////////////////////////////////////////////////////////////////////////
   // Unused channels are forced to zero here, not trusted upstream
   for (genvar i = 0; i < N_OUT; i++) begin : g_out
      assign out_shown[i] = res.out_used[i] ? res.outv[i] // RULE_10
                                            : 32'h0000_0000;
   end
   for (genvar j = 0; j < N_IN; j++) begin : g_in
      assign force_shown[j] = res.in_used[j] ? res.force_v[j] // RULE_11
                                             : 32'h0000_0000;
   end

   ////////////////////////////////////////////////////////////////////////
   // Register decode; narrow registers sit in the low bits
   always_comb begin
      rd_mux = 32'h0000_0000;
      rd_hit = 1'b1;
      out_idx = 3'(rd.addr - A_OUT1);
      in_idx = 2'(rd.addr - A_FORCE_A);
      if (rd.addr == A_INSTR_STATUS) begin
         rd_mux[RESTART_BIT] = restart_q; // RULE_12
      end else if (rd.addr == A_ERROR_CODE) begin
         rd_mux = {16'h0000, err_code}; // RULE_01
      end else if (rd.addr == A_INPUT_FAULT) begin
         rd_mux[FAULT_LSB +: N_IN] = res.in_fault; // RULE_04 RULE_05
      end else if (rd.addr == A_SUM) begin
         rd_mux = res.sum; // RULE_06
      end else if (rd.addr == A_DIFF) begin
         rd_mux = res.diff; // RULE_07
      end else if (rd.addr >= A_OUT1 && rd.addr < A_OUT1 + 8'(N_OUT)) begin
         rd_mux = out_shown[out_idx]; // RULE_09
      end else if (rd.addr >= A_FORCE_A &&
                   rd.addr < A_FORCE_A + 8'(N_IN)) begin
         rd_mux = force_shown[in_idx]; // RULE_11
      end else begin
         rd_hit = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Answer one cycle after the request; reply carries the old flag
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rd_valid_q <= 1'b0;
         rd_data_q <= RD_DATA_RST;
         rd_unmapped_q <= 1'b0;
      end else begin
         rd_valid_q <= rd.req;
         rd_unmapped_q <= rd.req && !rd_hit;
         if (rd.req) begin
            rd_data_q <= rd_mux;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Restart flag: set at every start, fieldbus status reads leave it
   assign status_rd_clr = rd.req && rd.addr == A_INSTR_STATUS &&
                          rd.src != SRC_FIELDBUS;
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         restart_q <= RESTART_RST; // RULE_12
      end else if (status_rd_clr || fieldbus_restart_clr) begin
         restart_q <= 1'b0; // RULE_12
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   restart_clear_a: assert property (@(posedge core_clk) // RULE_12
      disable iff (!arst_n)
      status_rd_clr |=> !restart_q ##1 (restart_q == 1'b0))
      else $error("restart flag not cleared by status read");
   fieldbus_keep_a: assert property (@(posedge core_clk) // RULE_12
      disable iff (!arst_n)
      rd.req && rd.src == SRC_FIELDBUS && !fieldbus_restart_clr
      |=> restart_q == $past(restart_q))
      else $error("fieldbus read changed restart flag");
   reply_flag_a: assert property (@(posedge core_clk) // RULE_12
      disable iff (!arst_n)
      rd.req && rd.addr == A_INSTR_STATUS
      |=> rd_valid_q && rd_data_q[RESTART_BIT] == $past(restart_q))
      else $error("status reply lost the restart flag");
   status_word_a: assert property (@(posedge core_clk) // RULE_04
      disable iff (!arst_n)
      rd.req && rd.addr == A_INPUT_FAULT
      |=> rd_data_q == {28'h000_0000, $past(res.in_fault)})
      else $error("status word does not mirror input faults");
   sum_read_a: assert property (@(posedge core_clk) // RULE_06
      disable iff (!arst_n)
      rd.req && rd.addr == A_SUM |=> rd_data_q == $past(res.sum))
      else $error("sum read mismatch");
   diff_read_a: assert property (@(posedge core_clk) // RULE_07
      disable iff (!arst_n)
      rd.req && rd.addr == A_DIFF |=> rd_data_q == $past(res.diff))
      else $error("difference read mismatch");
   unused_out_a: assert property (@(posedge core_clk) // RULE_10
      disable iff (!arst_n)
      rd.req && rd.addr >= A_OUT1 && rd.addr < A_OUT1 + 8'(N_OUT) &&
      !res.out_used[out_idx] |=> rd_data_q == 32'h0000_0000)
      else $error("unused output read nonzero");
   unused_force_a: assert property (@(posedge core_clk) // RULE_11
      disable iff (!arst_n)
      rd.req && rd.addr >= A_FORCE_A && rd.addr < A_FORCE_A + 8'(N_IN) &&
      !res.in_used[in_idx] |=> rd_data_q == 32'h0000_0000)
      else $error("unused force read nonzero");
   unmapped_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      rd.req && rd.addr > A_FORCE_A + 8'(N_IN) - 8'h01
      |=> rd_valid_q && rd_unmapped_q && rd_data_q == 32'h0000_0000)
      else $error("unmapped read not flagged");

   // Answer timing: one strobe per request, data held while idle
   answer_strobe_a: assert property (@(posedge core_clk)
      disable iff (!arst_n)
      rd.req |=> rd_valid_q)
      else $error("read request not answered");
   idle_quiet_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      !rd.req |=> !rd_valid_q && !rd_unmapped_q && $stable(rd_data_q))
      else $error("answer changed without a request");
   mapped_flag_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      rd.req && rd_hit |=> !rd_unmapped_q)
      else $error("mapped read flagged as unmapped");

   // Register contents against their sources
   error_read_a: assert property (@(posedge core_clk) // RULE_01
      disable iff (!arst_n)
      rd.req && rd.addr == A_ERROR_CODE
      |=> rd_data_q == {16'h0000, $past(err_code)})
      else $error("error code read mismatch");
   fault_high_zero_a: assert property (@(posedge core_clk) // RULE_05
      disable iff (!arst_n)
      rd.req && rd.addr == A_INPUT_FAULT
      |=> rd_data_q[31:FAULT_LSB+N_IN] == '0)
      else $error("unassigned status bits not zero");
   status_bits_a: assert property (@(posedge core_clk) // RULE_12
      disable iff (!arst_n)
      rd.req && rd.addr == A_INSTR_STATUS
      |=> rd_data_q == (32'($past(restart_q)) << RESTART_BIT))
      else $error("instrument status holds stray bits");
   used_out_a: assert property (@(posedge core_clk) // RULE_09
      disable iff (!arst_n)
      rd.req && rd.addr >= A_OUT1 && rd.addr < A_OUT1 + 8'(N_OUT) &&
      res.out_used[out_idx] |=> rd_data_q == $past(res.outv[out_idx]))
      else $error("used output read mismatch");
   used_force_a: assert property (@(posedge core_clk) // RULE_11
      disable iff (!arst_n)
      rd.req && rd.addr >= A_FORCE_A && rd.addr < A_FORCE_A + 8'(N_IN) &&
      res.in_used[in_idx] |=> rd_data_q == $past(res.force_v[in_idx]))
      else $error("used force read mismatch");
   // Only a new program start may raise the flag again
   restart_stays_a: assert property (@(posedge core_clk) // RULE_12
      disable iff (!arst_n)
      !restart_q |=> !restart_q)
      else $error("restart flag rose without a reset");
   restart_clr_c: cover property (@(posedge core_clk) disable iff (!arst_n)
      restart_q ##1 status_rd_clr ##1 !restart_q);
   fieldbus_read_c: cover property (@(posedge core_clk) disable iff (!arst_n)
      rd.req && rd.addr == A_INSTR_STATUS && rd.src == SRC_FIELDBUS);
   unused_out_c: cover property (@(posedge core_clk) disable iff (!arst_n)
      rd.req && rd.addr == A_OUT1 && !res.out_used[0]);
   used_force_c: cover property (@(posedge core_clk) disable iff (!arst_n)
      rd.req && rd.addr == A_FORCE_A + 8'h01 && res.in_used[1]);

endmodule

// file: fb_poll_master.sv
// External master model that polls the result registers
`timescale 1ns/100ps
module fb_poll_master
   import fb_result_pkg::*;
(
   // Clock
   input wire logic core_clk,
   // Read request towards the registers
   output rd_req_t rd,
   // Read answer
   input wire logic rd_valid_q,
   input wire logic [31:0] rd_data_q,
   input wire logic rd_unmapped_q
);
   ////////////////////////////////////////////////////////////////////////
   // Idle port; a released index is inverted so a stale one never matches
   initial rd = '{req: 1'b0, addr: 8'hFF, src: SRC_SERIAL};

   // One read: request for one cycle, answer sampled one cycle after
   task automatic read(input logic [7:0] a, input rd_src_t s,
      output logic [31:0] d, output logic u, output logic v);
      @(posedge core_clk);
      rd <= '{req: 1'b1, addr: a, src: s};
      @(posedge core_clk);
      rd <= '{req: 1'b0, addr: ~a, src: s};
      @(posedge core_clk);
      v = rd_valid_q;
      d = rd_data_q;
      u = rd_unmapped_q;
   endtask

   // A value is read together with the error code that qualifies it
   task automatic read_guarded(input logic [7:0] a, output logic [31:0] d,
      output logic [31:0] code);
      logic u;
      logic v;
      read(a, SRC_SERIAL, d, u, v);
      read(A_ERROR_CODE, SRC_SERIAL, code, u, v);
   endtask
endmodule

// file: fb_result_regs_tb.sv
// Self-checking bench of the function block result registers
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; \
   $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module fb_result_regs_tb
   import fb_result_pkg::*;
();
   logic core_clk;
   logic arst_n;
   rd_req_t rd;
   logic fieldbus_restart_clr;
   fb_result_t res;
   err_rep_t err;
   logic rd_valid_q;
   logic [31:0] rd_data_q;
   logic rd_unmapped_q;
   logic restart_q;
   logic [31:0] gd;
   logic [31:0] gc;
   int failures = 0;
   int n_checks = 0;
   int cycles = 0;

   fb_result_regs fb_result_regs_inst (.core_clk(core_clk), .arst_n(arst_n),
      .rd(rd), .fieldbus_restart_clr(fieldbus_restart_clr), .res(res),
      .err(err), .rd_valid_q(rd_valid_q), .rd_data_q(rd_data_q),
      .rd_unmapped_q(rd_unmapped_q), .restart_q(restart_q));
   fb_poll_master fb_poll_master_inst (.core_clk(core_clk), .rd(rd),
      .rd_valid_q(rd_valid_q), .rd_data_q(rd_data_q),
      .rd_unmapped_q(rd_unmapped_q));

   ////////////////////////////////////////////////////////////////////////
   // 20 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   // Cut a hang short; the whole run needs about 115 cycles
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         give_verdict();
      end
   end

   task automatic give_verdict();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Read one index and compare data, answer strobe and unmapped flag
   task automatic rdchk(input logic [7:0] a, input rd_src_t s,
      input logic [31:0] e);
      logic [31:0] d;
      logic u;
      logic v;
      fb_poll_master_inst.read(a, s, d, u, v);
      `CHK(v, 1'b1)
      `CHK(d, e)
      `CHK(u, (a > 8'h10))
   endtask

   // Report one error for a single cycle, error kept present
   task automatic rep(input logic [2:0] c, input logic [7:0] code);
      @(posedge core_clk);
      err <= '{present: 1'b1, valid: 1'b1, chan: c, code: code};
      @(posedge core_clk);
      err.valid <= 1'b0;
   endtask

   task automatic clr_err();
      @(posedge core_clk);
      err.present <= 1'b0;
   endtask

   task automatic hold_reset();
      repeat (8) @(posedge core_clk);
      arst_n <= 1'b1;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      arst_n = 1'b0;
      fieldbus_restart_clr = 1'b0;
      err = '0;
      res = '0;
      res.sum = 32'h1234_5678;
      res.diff = 32'hFEDC_BA98;
      for (int i = 0; i < N_OUT; i++) res.outv[i] = 32'h1000_0000 + i;
      for (int i = 0; i < N_IN; i++) res.force_v[i] = 32'hA000_0000 + i;
      res.out_used = 8'h5A;
      res.in_used = 4'h6;
      res.in_fault = 4'hA;
      hold_reset();
      `CHK(restart_q, 1'b1)
      rdchk(A_INSTR_STATUS, SRC_FIELDBUS, 32'h0000_0002);
      `CHK(restart_q, 1'b1)
      rdchk(A_INSTR_STATUS, SRC_ETHERNET, 32'h0000_0002);
      `CHK(restart_q, 1'b0)
      rdchk(A_INSTR_STATUS, SRC_SERIAL, 32'h0000_0000);
      rdchk(A_ERROR_CODE, SRC_SERIAL, 32'h0000_0000);
      rdchk(A_INPUT_FAULT, SRC_SERIAL, 32'h0000_000A);
      fb_poll_master_inst.read_guarded(A_SUM, gd, gc);
      `CHK(gd, res.sum)
      `CHK(gc, 32'h0000_0000)
      rdchk(A_DIFF, SRC_SERIAL, res.diff);
      for (int i = 0; i < N_OUT; i++)
         rdchk(8'(A_OUT1 + i), SRC_SERIAL,
            res.out_used[i] ? res.outv[i] : 32'h0000_0000);
      for (int i = 0; i < N_IN; i++)
         rdchk(8'(A_FORCE_A + i), SRC_SERIAL,
            res.in_used[i] ? res.force_v[i] : 32'h0000_0000);
      rdchk(8'h11, SRC_SERIAL, 32'h0000_0000);
      rdchk(8'hFF, SRC_SERIAL, 32'h0000_0000);
      // Second report in a row must not replace the first
      rep(3'h2, 8'h11);
      rep(3'h3, 8'h63);
      rdchk(A_ERROR_CODE, SRC_SERIAL, 32'h0000_07E1);
      clr_err();
      rdchk(A_ERROR_CODE, SRC_SERIAL, 32'h0000_0000);
      rep(3'h0, 8'hFF);
      rdchk(A_ERROR_CODE, SRC_SERIAL, 32'h0000_00FF);
      clr_err();
      rep(3'h4, 8'h00);
      rdchk(A_ERROR_CODE, SRC_SERIAL, 32'h0000_0FA0);
      // Second reset, then the dedicated fieldbus clear
      @(posedge core_clk);
      arst_n <= 1'b0;
      hold_reset();
      rdchk(A_ERROR_CODE, SRC_FIELDBUS, 32'h0000_0000);
      @(posedge core_clk);
      fieldbus_restart_clr <= 1'b1;
      @(posedge core_clk);
      fieldbus_restart_clr <= 1'b0;
      @(posedge core_clk);
      `CHK(restart_q, 1'b0)
      rdchk(A_INSTR_STATUS, SRC_FIELDBUS, 32'h0000_0000);
      give_verdict();
   end
endmodule
